// ==== bac_top.sv ====
// Busy indicator, alarm output and gate code calculation.
// Assumes configuration, samples and strobes come from serial and ADC
// logic on mclk; the lookup memory answers one cycle after lutAddr.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Busy during conversion, power-up, calculation, EEPROM or calibration.
// - Serial access works whatever busy shows.
// - Multi-scan modes hold busy to scan end, storage, alarm check.
// - Continuous mode not busy; clearing it holds busy to scan halt.
// - Single mode holds busy until this channel is stored, checked.
// - Own limits per temperature and current channel; flags record source.
// - Enables, polarity, style, threshold mode set by alarm configuration.
// - Style bit selects comparator or interrupt output.
// - Comparator style follows live alarm condition.
// - Interrupt style latches until flag read; rearms on new trip.
// - Temperature window bits choose window or hysteresis thresholds.
// - Current window bits choose window or hysteresis thresholds.
// - Window alarm sets outside window, clears inside past hysteresis.
// - Window hysteresis is 8 to 64 LSBs from the two-bit field.
// - Hysteresis alarm sets above high, clears below low.
// - Pin and clamps derive from alarm state, style, clamp enables.
// - Gate channels are calculated independently.
// - Set point plus two terms in 16-bit signed, clamped to 0..4095.
// - Recalculate on a source's first sample, then when it moved by at least the hysteresis.
// - Sample maps to pointer, table read, adjacent entries interpolated.
// - New code goes to DAC under load bit, even if unchanged.
module bac_top
    import bac_pkg::*;
(
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rstn,
    // Activity sources
    input  wire logic                         convStart,
    input  wire logic                         powerUpActive,
    input  wire logic                         eepromReadActive,
    input  wire logic                         eepromWriteActive,
    input  wire logic                         calibrationActive,
    // Conversion configuration
    input  wire logic                         convClockSelectHi,
    input  wire logic                         convClockSelectLo,
    input  wire logic                         continuousConversionFlag,
    // ADC results, index 0 temp1, 1 current1, 2 temp2, 3 current2
    input  wire logic                         sampleValid,
    input  wire logic [1:0]                   sampleSource,
    input  wire logic [SAMPLE_W-1:0]          sampleData,
    input  wire logic                         sampleLast,
    // Alarm configuration
    input  wire logic [NUM_SRC-1:0]           alarmEnable,
    input  wire logic                         alarmPolarityHigh,
    input  wire logic                         alarmOutputStyle,
    input  wire logic                         temp1WindowSelect,
    input  wire logic                         temp2WindowSelect,
    input  wire logic                         current1WindowSelect,
    input  wire logic                         current2WindowSelect,
    input  wire logic [1:0]                   alarmHysteresisField,
    input  wire logic [NUM_CH-1:0]            gateClampEnable,
    input  wire logic [NUM_SRC-1:0][SAMPLE_W-1:0] alarmHigh,
    input  wire logic [NUM_SRC-1:0][SAMPLE_W-1:0] alarmLow,
    input  wire logic                         flagRead,
    // Gate calculation configuration
    input  wire logic [NUM_CH-1:0]            loadDacBit,
    input  wire logic [NUM_CH-1:0][SAMPLE_W-1:0] gateSetPointCode,
    input  wire logic [SAMPLE_W-1:0]          tempCalcHysteresis,
    input  wire logic [SAMPLE_W-1:0]          apcCalcHysteresis,
    // Lookup memory
    output logic [LUT_ADDR_W-1:0]             lutAddr,
    input  wire logic [TERM_W-1:0]            lutData,
    // Status and outputs
    output logic                              busy,
    output logic                              alarmPin,
    output logic [NUM_SRC-1:0]                alarmFlags,
    output logic [NUM_CH-1:0]                 gateClamp,
    output logic [NUM_CH-1:0][SAMPLE_W-1:0]   dacCode,
    output logic [NUM_CH-1:0]                 dacLoad
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rstSync;
    logic       rstnSync;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rstSync <= 2'h0;
        end
        else
        begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end

    assign rstnSync = rstSync[1];

    // ------------------------------------------------------------
    // Alarm channels
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] windowSel;
    logic [NUM_SRC-1:0] alarmState;
    logic [HYST_W-1:0]  alarmHyst;

    assign windowSel = {current2WindowSelect, temp2WindowSelect,
                        current1WindowSelect, temp1WindowSelect};
    assign alarmHyst = ALARM_HYST_BASE << alarmHysteresisField;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi = gi + 1)
        begin : gAlarm
            bac_alarm_chan uChan (
                .mclk        (mclk),
                .rstn        (rstnSync),
                .alarmEnable (alarmEnable[gi]),
                .windowMode  (windowSel[gi]),
                .hystAmount  (alarmHyst),
                .limitHigh   (alarmHigh[gi]),
                .limitLow    (alarmLow[gi]),
                .sampleValid (sampleValid && sampleSource == 2'(gi)),
                .sampleData  (sampleData),
                .alarmState  (alarmState[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        bac_calc_state_type                 calc;
        logic [1:0]                         src;
        logic [SAMPLE_W-1:0]                calcSample;
        logic signed [TERM_W-1:0]           entry0;
        logic [NUM_SRC-1:0]                 haveLast;
        logic [NUM_SRC-1:0][SAMPLE_W-1:0]   lastUsed;
        logic [NUM_SRC-1:0]                 pend;
        logic [NUM_SRC-1:0][SAMPLE_W-1:0]   pendSample;
        logic [NUM_SRC-1:0][TERM_W-1:0]     term;
        logic [NUM_CH-1:0][SAMPLE_W-1:0]    codePend;
        logic [NUM_CH-1:0]                  codeFresh;
        logic [NUM_CH-1:0][SAMPLE_W-1:0]    dacCode;
        logic [NUM_CH-1:0]                  dacLoad;
        logic [LUT_ADDR_W-1:0]              lutAddr;
        logic                               convBusy;
        logic                               haltBusy;
        logic                               contPrev;
        logic [NUM_SRC-1:0]                 alarmPrev;
        logic                               intLatch;
        logic [NUM_SRC-1:0]                 flags;
        logic                               alarmPin;
        logic [NUM_CH-1:0]                  clamp;
        logic                               busy;
    } bac_top_state_type;

    bac_top_state_type cur;
    bac_top_state_type next_cur;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [SAMPLE_W-1:0]      hyst;
        logic [SAMPLE_W-1:0]      delta;
        logic [PTR_W-1:0]         ptr;
        logic [PTR_W-1:0]         ptrNext;
        logic [FRAC_W-1:0]        frac;
        logic signed [TERM_W:0]   slope;
        logic signed [TERM_W+FRAC_W+1:0] prod;
        logic signed [TERM_W-1:0] sum;
        logic [NUM_SRC-1:0]       rising;
        logic                     logical;
        logic                     scanDone;
        logic                     chSel;
        logic [1:0]               pick;
        logic                     found;
        hyst     = '0;
        delta    = '0;
        ptr      = cur.calcSample[SAMPLE_W-1:FRAC_W];
        ptrNext  = (ptr == '1) ? ptr : ptr + 1'b1;
        frac     = cur.calcSample[FRAC_W-1:0];
        slope    = $signed({lutData[TERM_W-1], lutData})
                 - $signed({cur.entry0[TERM_W-1], cur.entry0});
        prod     = slope * $signed({1'b0, frac});
        chSel    = cur.src[SRC_CH_BIT];
        sum      = '0;
        pick     = 2'h0;
        found    = 1'b0;
        rising   = '0;
        logical  = 1'b0;
        scanDone = 1'b0;
        next_cur = cur;
        next_cur.dacLoad = '0;

        // gate sample movement against last used
        for (int s = 0; s < NUM_SRC; s++)
        begin
            hyst  = (s % 2 == 0) ? tempCalcHysteresis : apcCalcHysteresis;
            delta = (sampleData >= cur.lastUsed[s])
                  ? sampleData - cur.lastUsed[s]
                  : cur.lastUsed[s] - sampleData;
            if (sampleValid && sampleSource == 2'(s)
                && (!cur.haveLast[s] || delta >= hyst))
            begin
                next_cur.pend[s]       = 1'b1;
                next_cur.pendSample[s] = sampleData;
            end
        end

        // one sequencer serves both channels in turn
        for (int s = NUM_SRC - 1; s >= 0; s--)
        begin
            if (cur.pend[s])
            begin
                pick  = 2'(s);
                found = 1'b1;
            end
        end

        case (cur.calc)
            CALC_IDLE:
            begin
                if (found)
                begin
                    next_cur.src            = pick;
                    next_cur.calcSample     = cur.pendSample[pick];
                    next_cur.lastUsed[pick] = cur.pendSample[pick];
                    next_cur.haveLast[pick] = 1'b1;
                    if (!(sampleValid && sampleSource == pick))
                    begin
                        next_cur.pend[pick] = 1'b0;
                    end
                    next_cur.lutAddr = {pick,
                        cur.pendSample[pick][SAMPLE_W-1:FRAC_W]};
                    next_cur.calc    = CALC_FIRST;
                end
            end
            CALC_FIRST:
            begin
                // Entry p arrives next cycle; request p+1, or p again when p is the last entry
                next_cur.lutAddr = {cur.src, ptrNext};
                next_cur.calc    = CALC_SECOND;
            end
            CALC_SECOND:
            begin
                next_cur.entry0 = lutData;
                next_cur.calc   = CALC_SUM;
            end
            CALC_SUM:
            begin
                next_cur.term[cur.src] = cur.entry0
                    + TERM_W'(prod >>> FRAC_W);
                // 16-bit signed sum, clamped to DAC range
                sum = $signed({SET_PAD, gateSetPointCode[chSel]})
                    + $signed(next_cur.term[{chSel, 1'b0}])
                    + $signed(next_cur.term[{chSel, 1'b1}]);
                if (sum[TERM_W-1])
                begin
                    next_cur.codePend[chSel] = DAC_CODE_MIN;
                end
                else if (sum > $signed({SET_PAD, DAC_CODE_MAX}))
                begin
                    next_cur.codePend[chSel] = DAC_CODE_MAX;
                end
                else
                begin
                    next_cur.codePend[chSel] = sum[SAMPLE_W-1:0];
                end
                next_cur.codeFresh[chSel] = 1'b1;
                next_cur.calc = CALC_IDLE;
            end
            default:
            begin
                next_cur.calc = CALC_IDLE;
            end
        endcase

        // forward every new code under load bit
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (next_cur.codeFresh[c] && loadDacBit[c])
            begin
                next_cur.dacCode[c]   = next_cur.codePend[c];
                next_cur.dacLoad[c]   = 1'b1;
                next_cur.codeFresh[c] = 1'b0;
            end
        end

        // multi modes end on last channel
        // single mode ends on this channel
        scanDone = sampleValid
            && ({convClockSelectHi, convClockSelectLo} == CKSEL_SINGLE
                || sampleLast);
        if (scanDone)
        begin
            next_cur.convBusy = 1'b0;
        end
        if (convStart && !continuousConversionFlag)
        begin
            next_cur.convBusy = 1'b1;
        end
        // leaving continuous holds until scan halts
        next_cur.contPrev = continuousConversionFlag;
        if (sampleValid && sampleLast)
        begin
            next_cur.haltBusy = 1'b0;
        end
        if (cur.contPrev && !continuousConversionFlag)
        begin
            next_cur.haltBusy = 1'b1;
        end

        // sticky source flags, a new trip beats a read
        rising             = alarmState & ~cur.alarmPrev;
        next_cur.alarmPrev = alarmState;
        next_cur.flags     = (cur.flags & ~{NUM_SRC{flagRead}}) | rising;
        // latch until flag read, rearm on trip
        next_cur.intLatch  = (cur.intLatch && !flagRead) || (|rising);
        logical = alarmOutputStyle ? (|alarmState) : next_cur.intLatch;
        next_cur.alarmPin = alarmPolarityHigh ? logical : !logical;
        // clamp per channel under its enable
        for (int c = 0; c < NUM_CH; c++)
        begin
            next_cur.clamp[c] = gateClampEnable[c]
                && (alarmState[2*c] || alarmState[2*c+1]);
        end

        // busy never gates the register inputs
        next_cur.busy = next_cur.convBusy || next_cur.haltBusy
            || powerUpActive || eepromReadActive || eepromWriteActive
            || calibrationActive || (|next_cur.pend)
            || next_cur.calc != CALC_IDLE;
    end

    always_ff @(posedge mclk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Pin rests inactive during reset only when polarity is high;
    // the first clocked edge applies the programmed polarity.
    assign lutAddr    = cur.lutAddr;
    assign busy       = cur.busy;
    assign alarmPin   = cur.alarmPin;
    assign alarmFlags = cur.flags;
    assign gateClamp  = cur.clamp;
    assign dacCode    = cur.dacCode;
    assign dacLoad    = cur.dacLoad;

endmodule

`default_nettype wire

// ==== bac_pkg.sv ====
// Shared constants and types of the bias, alarm and busy control block.
// Assumes one clock domain; all users import the whole package.
package bac_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int SAMPLE_W   = 12;
    localparam int TERM_W     = 16;
    localparam int PTR_W      = 6;
    localparam int FRAC_W     = SAMPLE_W - PTR_W;
    localparam int LUT_ADDR_W = 2 + PTR_W;
    localparam int NUM_SRC    = 4;
    localparam int NUM_CH     = 2;
    localparam int HYST_W     = 7;

    // ------------------------------------------------------------
    // Codes and limits
    // ------------------------------------------------------------
    localparam logic [1:0]          CKSEL_SINGLE    = 2'h3;
    localparam logic [SAMPLE_W-1:0] DAC_CODE_MAX    = 12'hFFF;
    localparam logic [SAMPLE_W-1:0] DAC_CODE_MIN    = 12'h000;
    localparam logic [HYST_W-1:0]   ALARM_HYST_BASE = 7'h08;
    localparam logic [3:0]          SET_PAD         = 4'h0;

    // Source index: bit 0 picks table (0 temperature, 1 power
    // control), bit 1 picks the gate channel
    localparam int SRC_TYPE_BIT = 0;
    localparam int SRC_CH_BIT   = 1;

    // ------------------------------------------------------------
    // Gate calculation sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CALC_IDLE,
        CALC_FIRST,
        CALC_SECOND,
        CALC_SUM
    } bac_calc_state_type;

endpackage

// ==== bac_alarm_chan.sv ====
// One alarm comparator channel with window or hysteresis thresholds.
// Assumes all inputs come from logic on mclk.
`timescale 1ns/1ps
`default_nettype none

module bac_alarm_chan
    import bac_pkg::*;
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rstn,
    // Configuration
    input  wire logic                alarmEnable,
    input  wire logic                windowMode,
    input  wire logic [HYST_W-1:0]   hystAmount,
    input  wire logic [SAMPLE_W-1:0] limitHigh,
    input  wire logic [SAMPLE_W-1:0] limitLow,
    // Measurement
    input  wire logic                sampleValid,
    input  wire logic [SAMPLE_W-1:0] sampleData,
    // Result
    output logic                     alarmState
);

    typedef struct packed {
        logic alarm;
    } bac_chan_state_type;

    bac_chan_state_type cur;
    bac_chan_state_type next_cur;

    always_comb
    begin
        logic [SAMPLE_W:0] upper;
        logic [SAMPLE_W:0] lower;
        upper = {1'b0, sampleData} + {6'h00, hystAmount};
        lower = {1'b0, limitLow} + {6'h00, hystAmount};
        next_cur = cur;
        if (!alarmEnable)
        begin
            next_cur.alarm = 1'b0;
        end
        else if (sampleValid)
        begin
            if (windowMode)
            begin
                if (sampleData > limitHigh || sampleData < limitLow)
                begin
                    next_cur.alarm = 1'b1;
                end
                else if (upper <= {1'b0, limitHigh}
                         && {1'b0, sampleData} >= lower)
                begin
                    next_cur.alarm = 1'b0;
                end
            end
            else
            begin
                if (sampleData > limitHigh)
                begin
                    next_cur.alarm = 1'b1;
                end
                else if (sampleData < limitLow)
                begin
                    next_cur.alarm = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign alarmState = cur.alarm;

endmodule

`default_nettype wire

// ==== bac_lut_model.sv ====
// Lookup memory model: one-cycle read.
// Assumes lutAddr is {source, pointer}; ramps make term = +/- sample, capped at 4032.
`timescale 1ns/1ps
`default_nettype none

module bac_lut_model
    import bac_pkg::*;
(
    // Clock
    input  wire logic                  mclk,
    // Read port
    input  wire logic [LUT_ADDR_W-1:0] lutAddr,
    output logic      [TERM_W-1:0]     lutData
);
    logic [TERM_W-1:0] ramp;

    // entries in range
    // Peak 4032 keeps every sum away from 16-bit wrap
    assign ramp = {4'h0, lutAddr[PTR_W-1:0], 6'h00};
    always_ff @(posedge mclk)
    begin
        lutData <= lutAddr[PTR_W+SRC_TYPE_BIT] ? -ramp : ramp;
    end
endmodule

`default_nettype wire

// ==== bac_top_props.sv ====
// Port checker of bac_top.
// Assumes one mclk domain.
`timescale 1ns/1ps
`default_nettype none

module bac_top_props
    import bac_pkg::*;
(
    // Clock and reset
    input wire logic                rstn,
    input wire logic                mclk,
    // Stimulus
    input wire logic                convStart,
    input wire logic                continuousConversionFlag,
    input wire logic                sampleValid,
    input wire logic [1:0]          sampleSource,
    input wire logic [SAMPLE_W-1:0] sampleData,
    input wire logic [NUM_SRC-1:0]  alarmEnable,
    input wire logic                alarmPolarityHigh,
    input wire logic                alarmOutputStyle,
    input wire logic [NUM_SRC-1:0][SAMPLE_W-1:0] alarmHigh,
    input wire logic                flagRead,
    input wire logic [NUM_CH-1:0]   loadDacBit,
    input wire logic [SAMPLE_W-1:0] tempCalcHysteresis,
    // Outputs
    input wire logic                busy,
    input wire logic                alarmPin,
    input wire logic [NUM_SRC-1:0]  alarmFlags,
    input wire logic [NUM_CH-1:0]   dacLoad
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence s_trip;
        sampleValid && alarmEnable[sampleSource]
            && sampleData > alarmHigh[sampleSource];
    endsequence
    sequence s_quietRead;
        !sampleValid [*3] ##0 (flagRead && !alarmOutputStyle);
    endsequence

    property p_busyConv;
        convStart && !continuousConversionFlag |=> busy;
    endproperty
    a_busyConv: assert property (p_busyConv) else $error("no busy");
    property p_contFall;
        $fell(continuousConversionFlag) |=> busy;
    endproperty
    a_contFall: assert property (p_contFall) else $error("no busy");
    property p_cmpTrip;
        s_trip ##0 alarmOutputStyle |-> ##2 alarmPin == alarmPolarityHigh;
    endproperty
    a_cmpTrip: assert property (p_cmpTrip) else $error("no pin");
    property p_intHold;
        !alarmOutputStyle && alarmPin == alarmPolarityHigh && !flagRead
            |=> alarmPin == alarmPolarityHigh;
    endproperty
    a_intHold: assert property (p_intHold) else $error("pin lost");
    property p_intClear;
        s_quietRead |-> ##[1:2] alarmPin != alarmPolarityHigh
            && alarmFlags == '0;
    endproperty
    a_intClear: assert property (p_intClear) else $error("pin kept");
    property p_cmpQuiet;
        (alarmOutputStyle && alarmEnable == '0 && $stable(alarmPolarityHigh))
            [*5] |-> alarmPin != alarmPolarityHigh;
    endproperty
    a_cmpQuiet: assert property (p_cmpQuiet) else $error("bad idle");
    property p_loadBit;
        (dacLoad & ~$past(loadDacBit)) == '0;
    endproperty
    a_loadBit: assert property (p_loadBit) else $error("bad load");
    property p_calcLat;
        sampleValid && sampleSource == 2'h0 && !busy && loadDacBit[0]
            && tempCalcHysteresis == '0 |-> ##5 dacLoad[0];
    endproperty
    a_calcLat: assert property (p_calcLat) else $error("late load");
endmodule

bind bac_top bac_top_props u_props (.*);

`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench of bac_top.
// Assumes one mclk; inputs change by NBA at rising edges.
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import bac_pkg::*;
;
    localparam int SET0 = 1000;
    logic mclk, rstn, convStart, continuousConversionFlag, flagRead;
    logic convClockSelectHi, convClockSelectLo, sampleValid, sampleLast;
    logic alarmPolarityHigh, alarmOutputStyle, temp1WindowSelect;
    logic gotLoad, alarmPin, busy;
    logic [3:0] act, alarmEnable, alarmFlags;
    logic [1:0] sampleSource, alarmHysteresisField, gateClampEnable;
    logic [1:0] loadDacBit, gateClamp, dacLoad;
    logic [SAMPLE_W-1:0] sampleData, tempCalcHysteresis;
    logic [NUM_SRC-1:0][SAMPLE_W-1:0] alarmHigh, alarmLow;
    logic [NUM_CH-1:0][SAMPLE_W-1:0] gateSetPointCode, dacCode;
    logic [LUT_ADDR_W-1:0] lutAddr;
    logic [TERM_W-1:0] lutData;
    int nMismatch, numChecks;

    bac_top dut (
        .mclk, .rstn, .convStart, .powerUpActive(act[0]),
        .eepromReadActive(act[1]), .eepromWriteActive(act[2]),
        .calibrationActive(act[3]), .convClockSelectHi, .convClockSelectLo,
        .continuousConversionFlag, .sampleValid, .sampleSource, .sampleData,
        .sampleLast, .alarmEnable, .alarmPolarityHigh, .alarmOutputStyle,
        .temp1WindowSelect, .temp2WindowSelect(1'b0),
        .current1WindowSelect(1'b0), .current2WindowSelect(1'b0),
        .alarmHysteresisField, .gateClampEnable, .alarmHigh, .alarmLow,
        .flagRead, .loadDacBit, .gateSetPointCode, .tempCalcHysteresis,
        .apcCalcHysteresis(12'h000), .lutAddr, .lutData, .busy, .alarmPin,
        .alarmFlags, .gateClamp, .dacCode, .dacLoad
    );
    bac_lut_model lut (.mclk, .lutAddr, .lutData);

    task automatic finish_test;
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic checkBit(input logic a, input logic e);
        numChecks++;
        if (a !== e)
        begin
            nMismatch++;
            $display("MISMATCH %0t bit %b exp %b", $time, a, e);
        end
    endtask
    task automatic checkCode(input logic [11:0] a, input logic [11:0] e);
        numChecks++;
        if (a !== e)
        begin
            nMismatch++;
            $display("MISMATCH %0t code %h exp %h", $time, a, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Ten cycles cover a whole calculation
    task automatic samp(input logic [1:0] s, input logic [11:0] d,
                        input logic lst);
        gotLoad = 1'b0;
        {sampleValid, sampleSource, sampleData, sampleLast} <= {1'b1, s, d, lst};
        tick(1);
        sampleValid <= 1'b0;
        repeat (10)
        begin
            @(posedge mclk);
            if (dacLoad[s[1]] === 1'b1)
                gotLoad = 1'b1;
        end
    endtask
    task automatic calc(input logic [1:0] s, input logic [11:0] d,
                        input logic eLoad, input int eSum);
        samp(s, d, 1'b0);
        checkBit(gotLoad, eLoad);
        checkCode(dacCode[s[1]], eSum < 0 ? DAC_CODE_MIN :
                  eSum > 4095 ? DAC_CODE_MAX : 12'(eSum));
    endtask
    task automatic alm(input logic [11:0] d, input logic ePin);
        samp(2'h0, d, 1'b0);
        checkBit(alarmPin, ePin);
    endtask
    task automatic pulse(input logic conv);
        {convStart, flagRead} <= {conv, !conv};
        tick(1);
        {convStart, flagRead} <= 2'h0;
        tick(3);
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        #200us;
        nMismatch++;
        finish_test();
    end
    initial
    begin
        {rstn, convStart, act, convClockSelectHi, convClockSelectLo} = '0;
        {continuousConversionFlag, flagRead, sampleValid, sampleLast} = '0;
        {alarmOutputStyle, alarmPolarityHigh, temp1WindowSelect} = 3'h4;
        {sampleSource, sampleData, alarmEnable, alarmHysteresisField} = '0;
        {tempCalcHysteresis, alarmHigh, alarmLow} = '0;
        {gateClampEnable, loadDacBit} = 4'h7;
        gateSetPointCode = {12'h032, 12'h3E8};
        alarmHigh[0] = 12'hBB8;
        alarmLow[0] = 12'h3E8;
        tick(8);
        rstn <= 1'b1;
        tick(8);
        checkBit(alarmPin, 1'b1);
        checkBit(busy, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            act <= 4'h1 << i;
            tick(3);
            checkBit(busy, 1'b1);
            act <= 4'h0;
            tick(3);
            checkBit(busy, 1'b0);
        end
        for (int m = 3; m >= 0; m -= 3)
        begin
            {convClockSelectHi, convClockSelectLo} <= 2'(m);
            pulse(1'b1);
            checkBit(busy, 1'b1);
            samp(2'h1, 12'h000, 1'b0);
            checkBit(busy, m != 3);
            samp(2'h1, 12'h000, 1'b1);
            checkBit(busy, 1'b0);
        end
        continuousConversionFlag <= 1'b1;
        pulse(1'b1);
        checkBit(busy, 1'b0);
        continuousConversionFlag <= 1'b0;
        tick(2);
        checkBit(busy, 1'b1);
        samp(2'h1, 12'h000, 1'b1);
        checkBit(busy, 1'b0);
        calc(2'h0, 12'h1F4, 1'b1, SET0 + 500);
        calc(2'h1, 12'h7D0, 1'b1, SET0 + 500 - 2000);
        calc(2'h1, 12'h000, 1'b1, SET0 + 500);
        calc(2'h0, 12'hFFF, 1'b1, SET0 + 4032);
        tempCalcHysteresis <= 12'h010;
        calc(2'h0, 12'hFFA, 1'b0, SET0 + 4032);
        calc(2'h0, 12'hFEF, 1'b1, SET0 + 4032);
        checkCode(dacCode[1], 12'h000);
        calc(2'h2, 12'h064, 1'b1, 50 + 100);
        {alarmPolarityHigh, alarmEnable} <= 5'h11;
        alm(12'hDAC, 1'b1);
        checkBit(gateClamp[0], 1'b1);
        checkBit(alarmFlags[0], 1'b1);
        alm(12'h7D0, 1'b1);
        alm(12'h384, 1'b0);
        {temp1WindowSelect, alarmHysteresisField} <= 3'h5;
        alm(12'h1F4, 1'b1);
        alm(12'h3F2, 1'b1);
        alm(12'h3FC, 1'b0);
        alarmOutputStyle <= 1'b0;
        pulse(1'b0);
        alm(12'hDAC, 1'b1);
        alm(12'h7D0, 1'b1);
        pulse(1'b0);
        checkBit(alarmPin, 1'b0);
        checkBit(alarmFlags[0], 1'b0);
        {alarmOutputStyle, alarmPolarityHigh} <= 2'h2;
        tick(3);
        checkBit(alarmPin, 1'b1);
        finish_test();
    end
endmodule

`default_nettype wire
